// ===== pkg/icpd_defines.vh
// Shared constants for the I2C configuration port decoder
`ifndef ICPD_DEFINES_VH
`define ICPD_DEFINES_VH
`define ICPD_BASE7_RST 7'h40
`define ICPD_BASE10_RST 10'h3C0
`define ICPD_RES_CFG 2'h0
`define ICPD_RES_UPRI 2'h1
`define ICPD_RES_USEC 2'h2
`define ICPD_RES_RST 2'h3
`define ICPD_ADDR10_HDR 5'h1E
`define ICPD_KEY_W 64
`define ICPD_CLK_HZ 10000000
`define ICPD_SCL_MAX_HZ 400000
`define ICPD_MIN_RATIO_X10 75
`define ICPD_FIFO_DEPTH 16
`define ICPD_CMD_READ_ID 8'hE0
`define ICPD_CMD_KEY_LOAD 8'hF1
`define ICPD_CMD_ERASE 8'h0E
`define ICPD_CMD_WRITE 8'h70
`define ICPD_CMD_VERIFY 8'h73
// Identification word, value arbitrary
`define ICPD_ID_WORD 32'h0000_0A5A
`endif

// ===== hw/icpd_fifo.v
// Small synchronous FIFO holding queued response bytes
`timescale 1ns/1ps
module icpd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk_i, // Clock
  input wire rst_n_i, // Async reset, active low
  input wire flush_i, // Discard all content
  input wire in_valid_i, // Write request
  output wire in_ready_o, // Not full
  input wire [WIDTH-1:0] in_data_i, // Write data
  output wire out_valid_o, // Not empty
  input wire out_ready_i, // Read accept
  output wire [WIDTH-1:0] out_data_o // Head data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire do_wr = in_valid_i && !full && !flush_i;
  wire do_rd = out_ready_i && !empty && !flush_i;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];
  // Storage write
  always @(posedge core_clk_i) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
  // Pointers, flush clears both
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// ===== hw/icpd_cmd.v
// Command interpreter with access-key gate feeding the response FIFO
`timescale 1ns/1ps
`include "icpd_defines.vh"
module icpd_cmd (
  input wire core_clk_i, // Clock
  input wire rst_n_i, // Async reset, active low
  input wire intp_reset_i, // Reset interpreter
  input wire byte_valid_i, // Command byte strobe
  input wire [7:0] byte_i, // Command byte
  input wire [`ICPD_KEY_W-1:0] stored_key_i, // Key from settings row
  input wire key_check_enable_bit_i, // Key checking on
  input wire key_check_all_ops_bit_i, // Key applies to all ops
  input wire resp_ready_i, // FIFO has room
  output reg resp_valid_o, // Response byte strobe
  output reg [7:0] resp_data_o, // Response byte
  output reg key_ok_o, // Valid key presented
  output reg edit_pulse_o, // Allowed edit op
  output reg refused_pulse_o // Refused op
);
  localparam S_OP = 2'd0;
  localparam S_KEY = 2'd1;
  localparam S_ID = 2'd2;
  reg [1:0] state_reg;
  reg [3:0] cnt_reg;
  reg [`ICPD_KEY_W-1:0] key_sh_reg;
  wire [`ICPD_KEY_W-1:0] key_new = {key_sh_reg[`ICPD_KEY_W-9:0], byte_i};
  wire locked = key_check_enable_bit_i && !key_ok_o;
  wire is_edit = (byte_i == `ICPD_CMD_ERASE) || (byte_i == `ICPD_CMD_WRITE) ||
                 (byte_i == `ICPD_CMD_VERIFY);
  // ID word shifted so the next byte sits at the bottom
  wire [31:0] id_shifted = `ICPD_ID_WORD >> {~cnt_reg[1:0], 3'b000};
  // Opcode decode, key load and ID response
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_OP;
      cnt_reg <= 4'h0;
      key_sh_reg <= {`ICPD_KEY_W{1'b0}};
      key_ok_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_data_o <= 8'h00;
      edit_pulse_o <= 1'b0;
      refused_pulse_o <= 1'b0;
    end else if (intp_reset_i) begin
      state_reg <= S_OP;
      cnt_reg <= 4'h0;
      resp_valid_o <= 1'b0;
      edit_pulse_o <= 1'b0;
      refused_pulse_o <= 1'b0;
    end else begin
      edit_pulse_o <= 1'b0;
      refused_pulse_o <= 1'b0;
      resp_valid_o <= 1'b0;
      case (state_reg)
        S_OP: begin
          if (byte_valid_i) begin
            if (byte_i == `ICPD_CMD_KEY_LOAD) begin
              state_reg <= S_KEY;
              cnt_reg <= 4'h0;
            end else if (byte_i == `ICPD_CMD_READ_ID) begin
              if (locked && key_check_all_ops_bit_i) begin
                refused_pulse_o <= 1'b1;
              end else begin
                state_reg <= S_ID;
                cnt_reg <= 4'h0;
              end
            end else if (is_edit) begin
              edit_pulse_o <= !locked;
              refused_pulse_o <= locked;
            end else begin
              refused_pulse_o <= locked;
            end
          end
        end
        S_KEY: begin
          if (byte_valid_i) begin
            key_sh_reg <= key_new;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h7) begin
              key_ok_o <= (key_new == stored_key_i);
              state_reg <= S_OP;
            end
          end
        end
        S_ID: begin
          if (resp_ready_i) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= id_shifted[7:0];
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h3) state_reg <= S_OP;
          end
        end
        default: state_reg <= S_OP;
      endcase
    end
  end
endmodule

// ===== hw/icpd_top.v
// I2C target port decoding configuration and user controller addresses
// What this block does
// - Target addresses are accepted in both 7-bit and 10-bit formats.
// - The master clocks SCL at 400 kHz at most and the port works at any rate below.
// - The port is active while the settings row is erased, and in user mode only if retained.
// - Only the config resource reaches configuration logic; user primary and user secondary are both user only.
// - Default base is 7-bit 1000000 or 10-bit 1111000000, shared by user controllers.
// - The two low address bits pick config, user primary, user secondary or reset.
// - All four decoded addresses are acknowledged whenever the port is active.
// - Queued response data keeps coming after an abandoned transaction.
// - A write to resource 3 resets the interpreter and flushes queued data.
// - With key checking on, write, verify and erase need a matching key.
// - With key checking on and no valid key, only ID read and key load are served, and ID read not with the all-ops bit set.
// - The key is 64 bits in the settings row, with enable and all-ops bits.
`timescale 1ns/1ps
`include "icpd_defines.vh"
module icpd_top #(
  parameter FIFO_DEPTH = `ICPD_FIFO_DEPTH
) (
  input wire core_clk_i, // Internal bus clock, 10 MHz
  input wire rst_n_i, // Async reset, active low
  input wire scl_i, // I2C clock, synchronous input
  input wire sda_i, // I2C data in
  output reg sda_o, // I2C data out, always 0
  output reg sda_oe_o, // Pull SDA low when high
  input wire settings_erased_i, // Settings row erased
  input wire port_retain_i, // Keep port in user mode
  input wire user_mode_i, // Device in user mode
  input wire [6:0] base7_i, // 7-bit base address
  input wire [9:0] base10_i, // 10-bit base address
  input wire [`ICPD_KEY_W-1:0] stored_key_i, // Stored access key
  input wire key_check_enable_bit_i, // Key checking on
  input wire key_check_all_ops_bit_i, // Key for all ops
  output reg port_active_o, // Port active
  output reg [1:0] sel_res_o, // Last selected resource
  output reg upri_sel_o, // User primary selected
  output reg usec_sel_o, // User secondary selected
  output reg [7:0] user_wdata_o, // Byte to user controller
  output reg user_wstb_o, // User byte strobe
  output reg key_ok_o, // Valid key held
  output reg edit_o, // Allowed edit op pulse
  output reg refused_o, // Refused op pulse
  output reg intp_reset_o // Interpreter reset pulse
);
  // Byte engine states; ADDR2 takes the low 10-bit byte
  // and RACK waits for the master's acknowledge
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ADDR2 = 3'd2;
  localparam S_ACK = 3'd3;
  localparam S_WR = 3'd4;
  localparam S_RD = 3'd5;
  localparam S_RACK = 3'd6;
  // Sampled bus and edge detection
  // Reset high like the idle bus, so no false START
  // or SCL edge follows reset
  reg scl_q_reg;
  reg sda_q_reg;
  reg scl_p_reg;
  reg sda_p_reg;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
      scl_p_reg <= scl_q_reg;
      sda_p_reg <= sda_q_reg;
    end
  end
  // 400 kHz SCL at a 10 MHz clock gives 25 samples per bit, above the 7.5 floor
  wire scl_rise = scl_q_reg && !scl_p_reg;
  wire scl_fall = !scl_q_reg && scl_p_reg;
  // START and STOP: SDA edges while SCL stays high
  wire start_c = scl_q_reg && scl_p_reg && sda_p_reg && !sda_q_reg;
  wire stop_c = scl_q_reg && scl_p_reg && !sda_p_reg && sda_q_reg;
  wire active = settings_erased_i || (user_mode_i && port_retain_i);
  // Engine state, return state, shifter, bit count
  reg [2:0] state_reg;
  reg [2:0] ret_reg;
  reg [7:0] sh_reg;
  reg [3:0] bit_reg;
  reg rw_reg;
  reg is10_reg;
  reg first_reg;
  reg [1:0] res_reg;
  reg [7:0] tx_reg;
  // Resource code from low address bits
  function [1:0] res_of;
    input [9:0] a;
    begin
      res_of = a[1:0];
    end
  endfunction
  // Base match, ignoring the two resource bits
  function match;
    input [9:0] a;
    input [9:0] b;
    begin
      match = (a[9:2] == b[9:2]);
    end
  endfunction
  // 7-bit addresses widened to share one match
  wire [9:0] a7 = {3'b000, sh_reg[7:1]};
  wire [9:0] b7 = {3'b000, base7_i};
  reg [1:0] addr_hi_reg;
  wire [9:0] a10 = {addr_hi_reg, sh_reg};
  wire hdr10 = (sh_reg[7:3] == `ICPD_ADDR10_HDR);
  // Interpreter and response FIFO wiring
  // A byte is taken at the SCL fall after bit eight
  wire cfg_wstb = (state_reg == S_WR) && scl_fall && (bit_reg == 4'd8) &&
                  (res_reg == `ICPD_RES_CFG);
  wire rst_hit = (state_reg == S_WR) && scl_fall && (bit_reg == 4'd8) &&
                 (res_reg == `ICPD_RES_RST);
  wire ci_rvalid;
  wire [7:0] ci_rdata;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire ci_key_ok;
  wire ci_edit;
  wire ci_ref;
  // A read byte leaves the queue at its ninth SCL rise,
  // so a NACK ends the read without repeating it
  wire fifo_pop = (state_reg == S_RACK) && scl_rise && (res_reg == `ICPD_RES_CFG);
  // Interpreter stalls while the queue is full
  icpd_cmd u_cmd (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .intp_reset_i(rst_hit),
    .byte_valid_i(cfg_wstb),
    .byte_i(sh_reg),
    .stored_key_i(stored_key_i),
    .key_check_enable_bit_i(key_check_enable_bit_i),
    .key_check_all_ops_bit_i(key_check_all_ops_bit_i),
    .resp_ready_i(fifo_in_ready),
    .resp_valid_o(ci_rvalid),
    .resp_data_o(ci_rdata),
    .key_ok_o(ci_key_ok),
    .edit_pulse_o(ci_edit),
    .refused_pulse_o(ci_ref)
  );
  icpd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(rst_hit),
    .in_valid_i(ci_rvalid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(ci_rdata),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );
  // Byte engine: address, acknowledge, write and read phases
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      rw_reg <= 1'b0;
      is10_reg <= 1'b0;
      first_reg <= 1'b0;
      res_reg <= 2'h0;
      addr_hi_reg <= 2'h0;
      tx_reg <= 8'hFF;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      sel_res_o <= 2'h0;
      upri_sel_o <= 1'b0;
      usec_sel_o <= 1'b0;
      user_wdata_o <= 8'h00;
      user_wstb_o <= 1'b0;
      port_active_o <= 1'b0;
      key_ok_o <= 1'b0;
      edit_o <= 1'b0;
      refused_o <= 1'b0;
      intp_reset_o <= 1'b0;
    end else begin
      // Status outputs come from flops
      port_active_o <= active;
      key_ok_o <= ci_key_ok;
      edit_o <= ci_edit;
      refused_o <= ci_ref;
      intp_reset_o <= rst_hit;
      user_wstb_o <= 1'b0;
      // Port loss or STOP drops the transfer
      if (!active || stop_c) begin
        state_reg <= S_IDLE;
        first_reg <= 1'b0;
        sda_oe_o <= 1'b0;
        upri_sel_o <= 1'b0;
        usec_sel_o <= 1'b0;
      end else if (start_c) begin
        state_reg <= S_ADDR;
        bit_reg <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        // SDA moves only while SCL is low
        case (state_reg)
          S_ADDR, S_ADDR2, S_WR: begin
            if (scl_rise && bit_reg < 4'd8) begin
              sh_reg <= {sh_reg[6:0], sda_q_reg};
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'd8) begin
              bit_reg <= 4'h0;
              // First byte: address or 10-bit header
              if (state_reg == S_ADDR) begin
                rw_reg <= sh_reg[0];
                if (hdr10) begin
                  addr_hi_reg <= sh_reg[2:1];
                  // Read header only after a write header
                  if (sh_reg[0] && is10_reg && first_reg && sh_reg[2:1] == addr_hi_reg) begin
                    sda_oe_o <= 1'b1; // Repeated-start read of a 10-bit target
                    ret_reg <= S_RD;
                    state_reg <= S_ACK;
                  end else if (!sh_reg[0] && sh_reg[2:1] == base10_i[9:8]) begin
                    sda_oe_o <= 1'b1;
                    ret_reg <= S_ADDR2;
                    state_reg <= S_ACK;
                  end else begin
                    state_reg <= S_IDLE;
                  end
                end else if (match(a7, b7)) begin
                  res_reg <= res_of(a7);
                  is10_reg <= 1'b0;
                  first_reg <= 1'b1;
                  sda_oe_o <= 1'b1;
                  ret_reg <= sh_reg[0] ? S_RD : S_WR;
                  state_reg <= S_ACK;
                end else begin
                  state_reg <= S_IDLE;
                end
              end else if (state_reg == S_ADDR2) begin
                if (match(a10, base10_i)) begin
                  res_reg <= res_of(a10);
                  is10_reg <= 1'b1;
                  first_reg <= 1'b1;
                  sda_oe_o <= 1'b1;
                  ret_reg <= S_WR;
                  state_reg <= S_ACK;
                end else begin
                  state_reg <= S_IDLE;
                end
              end else begin
                sda_oe_o <= 1'b1; // Data bytes always acknowledged
                ret_reg <= S_WR;
                state_reg <= S_ACK;
                // Both user resources, primary and secondary, route bytes to user logic
                if (res_reg == `ICPD_RES_UPRI || res_reg == `ICPD_RES_USEC) begin
                  user_wdata_o <= sh_reg;
                  user_wstb_o <= 1'b1;
                end
              end
            end
          end
          S_ACK: begin
            // Selections follow the acked resource
            sel_res_o <= res_reg;
            upri_sel_o <= (res_reg == `ICPD_RES_UPRI);
            usec_sel_o <= (res_reg == `ICPD_RES_USEC);
            if (scl_fall) begin
              state_reg <= ret_reg;
              bit_reg <= 4'h0;
              if (ret_reg == S_RD) begin
                // Config reads drain the queue; others read as all ones
                tx_reg <= (res_reg == `ICPD_RES_CFG && fifo_out_valid) ? fifo_out_data : 8'hFF;
                sda_oe_o <= !((res_reg == `ICPD_RES_CFG && fifo_out_valid) ?
                              fifo_out_data[7] : 1'b1);
              end else begin
                sda_oe_o <= 1'b0;
              end
            end
          end
          S_RD: begin
            // Next bit after each SCL fall
            if (scl_fall) begin
              if (bit_reg == 4'd7) begin
                sda_oe_o <= 1'b0;
                state_reg <= S_RACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b1};
                sda_oe_o <= !tx_reg[6];
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          S_RACK: begin
            // Ninth bit: master ACK or NACK
            if (scl_rise) begin
              state_reg <= sda_q_reg ? S_IDLE : S_ACK; // Rest stays queued
              ret_reg <= S_RD;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== sim/icpd_top_props.sv
// Concurrent checks on the ports of the I2C configuration port decoder
`timescale 1ns/1ps
module icpd_top_props #(
  parameter FIFO_DEPTH = 16
) (
  input wire core_clk_i, // Clock
  input wire rst_n_i, // Async reset, active low
  input wire scl_i, // Serial clock level
  input wire sda_o, // Data out
  input wire sda_oe_o, // Data drive enable
  input wire settings_erased_i, // Settings row erased
  input wire port_retain_i, // Retain option
  input wire user_mode_i, // User mode
  input wire key_check_enable_bit_i, // Key checking on
  input wire port_active_o, // Port active
  input wire [1:0] sel_res_o, // Selected resource
  input wire upri_sel_o, // Primary user selected
  input wire usec_sel_o, // Secondary user selected
  input wire user_wstb_o, // User byte strobe
  input wire key_ok_o, // Valid key held
  input wire edit_o, // Edit pulse
  input wire refused_o, // Refused pulse
  input wire intp_reset_o // Interpreter reset pulse
);
  reg act_q; // Expected availability, one clock late
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Availability worked out from the mode inputs
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      act_q <= 1'b0;
    else
      act_q <= settings_erased_i | (user_mode_i & port_retain_i);
  end
  a_active_decode: assert property ($past(rst_n_i, 2) |-> port_active_o == act_q)
    else $error("port active does not follow the mode inputs");
  a_drive_active: assert property (sda_oe_o |-> port_active_o)
    else $error("data line driven while port inactive");
  a_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  a_ack_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*4])
    else $error("data drive too short");
  a_pulse_onehot: assert property ($onehot0({edit_o, refused_o, intp_reset_o}))
    else $error("several result pulses at once");
  a_edit_keyed: assert property (edit_o && key_check_enable_bit_i |-> key_ok_o)
    else $error("edit allowed without a valid key");
  a_refuse_locked: assert property (refused_o |-> key_check_enable_bit_i && !key_ok_o)
    else $error("operation refused while unlocked");
  a_user_excl: assert property (!(upri_sel_o && usec_sel_o))
    else $error("both user controllers selected");
  a_wstb_user: assert property (user_wstb_o |-> upri_sel_o || usec_sel_o)
    else $error("user strobe without user selection");
  a_sel_code: assert property (upri_sel_o || usec_sel_o |->
    sel_res_o == {usec_sel_o, upri_sel_o})
    else $error("user selection disagrees with resource code");
  c_edit: cover property (edit_o);
  c_refused: cover property (refused_o);
  c_reset: cover property (intp_reset_o);
  c_user: cover property (user_wstb_o);
endmodule
bind icpd_top icpd_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .settings_erased_i(settings_erased_i), .port_retain_i(port_retain_i),
  .user_mode_i(user_mode_i), .key_check_enable_bit_i(key_check_enable_bit_i),
  .port_active_o(port_active_o), .sel_res_o(sel_res_o), .upri_sel_o(upri_sel_o),
  .usec_sel_o(usec_sel_o), .user_wstb_o(user_wstb_o), .key_ok_o(key_ok_o), .edit_o(edit_o),
  .refused_o(refused_o), .intp_reset_o(intp_reset_o));

// ===== sim/icpd_i2c_master.sv
// Behavioural I2C master driving the serial clock and data toward the port
`timescale 1ns/1ps
module icpd_i2c_master (
  input wire core_clk_i, // Bench clock
  input wire sda_line_i, // Resolved data line
  output reg scl_o, // Serial clock, stands high when idle
  output reg sda_o // Data drive, 1 releases to the pull-up
);
  integer q = 10; // Quarter bit in clocks: 250 kHz, 40x below core clock
  reg s;
  integer j;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Wait a number of quarter bits, moving only on falling edges
  task qw(input integer n);
    repeat (n * q) @(negedge core_clk_i);
  endtask
  // One clock pulse with data set up while the clock is low
  task bit1(input b, output v);
    begin
      sda_o = b;
      qw(1);
      scl_o = 1'b1;
      qw(1);
      v = sda_line_i;
      qw(1);
      scl_o = 1'b0;
      qw(1);
    end
  endtask
  // Start or repeated start, leaving the clock low
  task start;
    begin
      sda_o = 1'b1;
      qw(1);
      scl_o = 1'b1;
      qw(1);
      sda_o = 1'b0;
      qw(1);
      scl_o = 1'b0;
      qw(1);
    end
  endtask
  // Stop, leaving the bus idle
  task stop;
    begin
      sda_o = 1'b0;
      qw(1);
      scl_o = 1'b1;
      qw(1);
      sda_o = 1'b1;
      qw(1);
    end
  endtask
  // Commands and data go out in write transactions
  task wbyte(input [7:0] b, output ack);
    begin
      for (j = 7; j >= 0; j = j - 1)
        bit1(b[j], s);
      bit1(1'b1, s);
      ack = ~s;
    end
  endtask
  // Read one byte, then acknowledge or end with a not-acknowledge
  task rbyte(input nack, output [7:0] b);
    begin
      for (j = 7; j >= 0; j = j - 1) begin
        bit1(1'b1, s);
        b[j] = s;
      end
      bit1(nack, s);
    end
  endtask
endmodule

// ===== sim/test_icpd_top.sv
// Self-checking bench for the I2C configuration port decoder
`timescale 1ns/1ps
`include "icpd_defines.vh"
module test_icpd_top;
  reg core_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg erased = 1'b1;
  reg retain = 1'b0;
  reg umode = 1'b0;
  reg [63:0] key = 64'h0000_0000_0000_0000;
  reg kc_en = 1'b0;
  reg kc_all = 1'b0;
  wire [6:0] base7 = `ICPD_BASE7_RST;
  wire [9:0] base10 = `ICPD_BASE10_RST;
  wire scl, sda_m, sda_o, sda_oe_o, port_active_o, upri_sel_o, usec_sel_o;
  wire user_wstb_o, key_ok_o, edit_o, refused_o, intp_reset_o;
  wire [1:0] sel_res_o;
  wire [7:0] user_wdata_o;
  wire sda_line = sda_m & ~(sda_oe_o & ~sda_o); // Pull-up unless someone pulls low
  wire [11:0] pulses = {edit_o, refused_o, intp_reset_o, user_wstb_o,
    user_wdata_o & {8{user_wstb_o}}}; // Observed result pulses
  integer seed = 57;
  integer n_fail = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  reg [7:0] d;
  reg [11:0] exp_p;
  reg [11:0] notes[$];
  icpd_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .settings_erased_i(erased), .port_retain_i(retain),
    .user_mode_i(umode), .base7_i(base7), .base10_i(base10), .stored_key_i(key),
    .key_check_enable_bit_i(kc_en), .key_check_all_ops_bit_i(kc_all),
    .port_active_o(port_active_o), .sel_res_o(sel_res_o), .upri_sel_o(upri_sel_o),
    .usec_sel_o(usec_sel_o), .user_wdata_o(user_wdata_o), .user_wstb_o(user_wstb_o),
    .key_ok_o(key_ok_o), .edit_o(edit_o), .refused_o(refused_o), .intp_reset_o(intp_reset_o));
  icpd_i2c_master m_u (.core_clk_i(core_clk_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_o(sda_m));
  initial forever #50 core_clk_i = ~core_clk_i;
  task results;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input string nm, input [63:0] seen, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Cut a hang short
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  // Each result pulse takes the oldest note
  always @(negedge core_clk_i) begin
    if ((edit_o | refused_o | intp_reset_o | user_wstb_o) === 1'b1) begin
      exp_p = (notes.size() > 0) ? notes.pop_front() : 12'h000;
      check("pulse", pulses, exp_p);
    end
  end
  task wb(input [7:0] b, input exp);
    reg a;
    begin
      m_u.wbyte(b, a);
      check("ack", a, exp);
    end
  endtask
  task rd(input last, input [7:0] exp);
    begin
      m_u.rbyte(last, d);
      check("rdata", d, exp);
    end
  endtask
  task a7(input [1:0] c, input rw, input exp);
    begin
      m_u.start;
      wb({base7[6:2], c, rw}, exp);
      if (exp)
        check("sel", sel_res_o, c);
    end
  endtask
  task a10(input [1:0] c);
    begin
      m_u.start;
      wb({5'h1E, base10[9:8], 1'b0}, 1'b1);
      wb({base10[7:2], c}, 1'b1);
      check("sel10", sel_res_o, c);
    end
  endtask
  task cmd(input [1:0] c, input [7:0] b);
    begin
      a7(c, 1'b0, 1'b1);
      wb(b, 1'b1);
      m_u.stop;
    end
  endtask
  // Read identification bytes, the master stalling with the clock low now and then
  task id_read(input integer first, input integer n);
    integer k;
    for (k = first; k < first + n; k = k + 1) begin
      if (k % 3 == 1)
        m_u.qw($random(seed) & 3);
      rd(k == first + n - 1, 8'(`ICPD_ID_WORD >> (24 - 8 * (k % 4))));
    end
  endtask
  task kload(input [63:0] k);
    integer b;
    begin
      a7(2'h0, 1'b0, 1'b1);
      wb(`ICPD_CMD_KEY_LOAD, 1'b1);
      for (b = 7; b >= 0; b = b - 1)
        wb(k[8 * b +: 8], 1'b1);
      m_u.stop;
    end
  endtask
  initial begin
    repeat (6) @(negedge core_clk_i);
    check("rst", {port_active_o, sda_oe_o, edit_o}, 3'b000);
    rst_n_i = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      {erased, retain, umode} = i[2:0];
      repeat (3) @(negedge core_clk_i);
      check("active", port_active_o, i[2] | (i[1] & i[0]));
    end
    {erased, retain, umode} = 3'b001;
    repeat (3) @(negedge core_clk_i);
    a7(2'h0, 1'b0, 1'b0);
    m_u.stop;
    {erased, retain, umode} = 3'b011;
    repeat (3) @(negedge core_clk_i);
    m_u.start;
    wb(8'h40, 1'b0);
    m_u.stop;
    for (i = 1; i < 3; i = i + 1) begin
      d = 8'($random(seed));
      notes.push_back({4'h1, d});
      a7(i[1:0], 1'b0, 1'b1);
      check("usel", {usec_sel_o, upri_sel_o}, i[1:0]);
      wb(d, 1'b1);
      m_u.stop;
    end
    cmd(2'h0, `ICPD_CMD_READ_ID);
    for (i = 0; i < 2; i = i + 1) begin
      a7(2'h0, 1'b1, 1'b1);
      id_read(i, 1);
      m_u.stop;
    end
    notes.push_back(12'h200);
    cmd(2'h3, 8'($random(seed)));
    a7(2'h0, 1'b1, 1'b1);
    rd(1'b1, 8'hFF);
    m_u.stop;
    repeat (4) cmd(2'h0, `ICPD_CMD_READ_ID);
    a7(2'h0, 1'b1, 1'b1);
    id_read(0, 16);
    a7(2'h0, 1'b1, 1'b1);
    rd(1'b1, 8'hFF);
    m_u.stop;
    a10(2'h0);
    wb(`ICPD_CMD_READ_ID, 1'b1);
    m_u.start;
    wb({5'h1E, base10[9:8], 1'b1}, 1'b1);
    id_read(0, 4);
    m_u.stop;
    notes.push_back(12'h200);
    a10(2'h3);
    wb(8'($random(seed)), 1'b1);
    m_u.stop;
    rst_n_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    kc_en = 1'b1;
    key = {$random(seed), $random(seed)};
    repeat (4) @(negedge core_clk_i);
    cmd(2'h0, `ICPD_CMD_READ_ID);
    a7(2'h0, 1'b1, 1'b1);
    id_read(0, 4);
    m_u.stop;
    notes.push_back(12'h400);
    cmd(2'h0, `ICPD_CMD_WRITE);
    kc_all = 1'b1;
    notes.push_back(12'h400);
    cmd(2'h0, `ICPD_CMD_READ_ID);
    a7(2'h0, 1'b1, 1'b1);
    rd(1'b1, 8'hFF);
    m_u.stop;
    kload(key ^ 64'h0000_0000_0000_0100);
    check("keyok", key_ok_o, 1'b0);
    kload(key);
    check("keyok", key_ok_o, 1'b1);
    for (i = 0; i < 3; i = i + 1) begin
      notes.push_back(12'h800);
      cmd(2'h0, i == 0 ? `ICPD_CMD_ERASE : (i == 1 ? `ICPD_CMD_WRITE : `ICPD_CMD_VERIFY));
    end
    repeat (4) @(negedge core_clk_i);
    check("notes", notes.size(), 0);
    results;
  end
endmodule
